// >>> rtl/ssa_pkg.sv
// Purpose: Shared constants and opcode encoding for the lane ALU
// Assumes: 32-bit data path, single core clock
// Notes: Opcode codes are local to this unit
package ssa_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned HALF_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned SHAMT_W = 5;
   localparam int unsigned ROT_W = 2;
   localparam int unsigned OP_W = 5;
   localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
   localparam logic [5:0] FULL_ASR = 6'h20;
   localparam logic [HALF_W-1:0] HALF_MAX = 16'hFFFF;
   localparam logic [BYTE_W-1:0] BYTE_MAX = 8'hFF;

   // Operation codes presented by the issuing logic
   localparam logic [OP_W-1:0] OP_SAT_ADD_HALVES = 5'h00;
   localparam logic [OP_W-1:0] OP_SAT_ADD_BYTES = 5'h01;
   localparam logic [OP_W-1:0] OP_SAT_SUB_HALVES = 5'h02;
   localparam logic [OP_W-1:0] OP_SAT_SUB_BYTES = 5'h03;
   localparam logic [OP_W-1:0] OP_PACK_BOTTOM_TOP = 5'h04;
   localparam logic [OP_W-1:0] OP_PACK_TOP_BOTTOM = 5'h05;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_BYTE = 5'h06;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_BYTE = 5'h07;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_HALF = 5'h08;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_HALF = 5'h09;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_DUAL_BYTE = 5'h0A;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_DUAL_BYTE = 5'h0B;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_BYTE_ADD = 5'h0C;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_HALF_ADD = 5'h0D;
   localparam logic [OP_W-1:0] OP_SIGN_EXT_DUAL_BYTE_ADD = 5'h0E;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_BYTE_ADD = 5'h0F;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_HALF_ADD = 5'h10;
   localparam logic [OP_W-1:0] OP_ZERO_EXT_DUAL_BYTE_ADD = 5'h11;
endpackage

// >>> rtl/ssa_sat_lanes.sv
// Purpose: Unsigned saturating add or subtract on byte or halfword lanes
// Assumes: Purely combinational, used inside the ALU top
// Notes: Carry or borrow out of each lane drives the clamp
`timescale 1ns/1ps
module ssa_sat_lanes (
   input wire logic [31:0] i_a,
   input wire logic [31:0] i_b,
   input wire logic i_sub,
   input wire logic i_bytes,
   output logic [31:0] o_res
);
   logic [31:0] byte_res;
   logic [31:0] half_res;

   // ------------------------------------------------------------
   // Byte lanes
   // ------------------------------------------------------------
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_byte
         logic [8:0] wide;
         // Nine-bit sum or difference, top bit flags the clamp
         always_comb begin
            if (i_sub) begin
               wide = {1'b0, i_a[gb*8 +: 8]} - {1'b0, i_b[gb*8 +: 8]};
               byte_res[gb*8 +: 8] = wide[8] ? 8'h00 : wide[7:0];
            end else begin
               wide = {1'b0, i_a[gb*8 +: 8]} + {1'b0, i_b[gb*8 +: 8]};
               byte_res[gb*8 +: 8] = wide[8] ? ssa_pkg::BYTE_MAX : wide[7:0];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Halfword lanes
   // ------------------------------------------------------------
   genvar gh;
   generate
      for (gh = 0; gh < 2; gh++) begin : g_half
         logic [16:0] wide;
         // Seventeen-bit sum or difference with clamp
         always_comb begin
            if (i_sub) begin
               wide = {1'b0, i_a[gh*16 +: 16]} - {1'b0, i_b[gh*16 +: 16]};
               half_res[gh*16 +: 16] = wide[16] ? 16'h0000 : wide[15:0];
            end else begin
               wide = {1'b0, i_a[gh*16 +: 16]} + {1'b0, i_b[gh*16 +: 16]};
               half_res[gh*16 +: 16] = wide[16] ? ssa_pkg::HALF_MAX : wide[15:0];
            end
         end
      end
   endgenerate

   // Lane width select
   assign o_res = i_bytes ? byte_res : half_res;
endmodule

// >>> rtl/ssa_extend.sv
// Purpose: Rotate, extend and optionally add for the extend family
// Assumes: Purely combinational, used inside the ALU top
// Notes: Dual forms keep halfword carries apart
`timescale 1ns/1ps
module ssa_extend (
   input wire logic [31:0] i_a,
   input wire logic [31:0] i_src,
   input wire logic [1:0] i_rot,
   input wire logic i_signed,
   input wire logic [1:0] i_size,
   input wire logic i_add,
   output logic [31:0] o_res
);
   logic [31:0] rot;
   logic [31:0] ext;
   logic [15:0] lo_sum;
   logic [15:0] hi_sum;

   // Rotate right by 0, 8, 16 or 24 positions
   always_comb begin
      unique case (i_rot)
         2'd0: rot = i_src;
         2'd1: rot = {i_src[7:0], i_src[31:8]};
         2'd2: rot = {i_src[15:0], i_src[31:16]};
         2'd3: rot = {i_src[23:0], i_src[31:24]};
      endcase
   end

   // Extension by size: 0 byte, 1 half, 2 dual byte
   always_comb begin
      unique case (i_size)
         2'd0: ext = {{24{i_signed & rot[7]}}, rot[7:0]};
         2'd1: ext = {{16{i_signed & rot[15]}}, rot[15:0]};
         default: ext = {{8{i_signed & rot[23]}}, rot[23:16],
                         {8{i_signed & rot[7]}}, rot[7:0]};
      endcase
   end

   // Separate halfword sums for dual forms
   assign lo_sum = i_a[15:0] + ext[15:0];
   assign hi_sum = i_a[31:16] + ext[31:16];

   // Final result choice
   always_comb begin
      if (!i_add) begin
         o_res = ext;
      end else if (i_size == 2'd2) begin
         o_res = {hi_sum, lo_sum};
      end else begin
         o_res = i_a + ext;
      end
   end
endmodule

// >>> rtl/ssa_alu.sv
// Purpose: Lane saturating, pack and extend datapath unit of the core
// Assumes: Operands from the register file, result written one cycle later
// Notes: No flag outputs exist, so condition flags are never touched
//
// Functional notes
// - Saturating halfword add, each lane clamped to 0..65535
// - Saturating byte add, each of four lanes clamped to 0..255
// - Saturating halfword subtract, each lane clamped at zero
// - Saturating byte subtract, each lane clamped at zero
// - Saturating lane operations leave condition flags alone
// - Pack bottom-top: low half from first, high from shifted second
// - Pack top-bottom: high half from first, low from shifted second
// - Bottom-top shift is logical left 0 to 31
// - Top-bottom shift is arithmetic right 1 to 32, code 0 means 32
// - Pack operations leave all flags alone
// - Extend source rotated right by 0, 8, 16 or 24
// - Byte extend takes bits 7..0, sign or zero extended to 32
// - Half extend takes bits 15..0, sign or zero extended to 32
// - Dual byte extend: bytes 0 and 2 each widened to 16 bits
// - Extend-add adds extended value to full first operand word
// - Dual extend-add adds each widened byte to its halfword
// - Extend operations leave all flags alone
`timescale 1ns/1ps
module ssa_alu (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic i_cond_pass,
   input wire logic [4:0] i_opcode,
   input wire logic [31:0] i_op_a,
   input wire logic [31:0] i_op_b,
   input wire logic [4:0] i_shift_amount,
   input wire logic [1:0] i_rotate_right_amount,
   input wire logic [3:0] i_dest_reg,
   output logic o_result_valid,
   output logic [31:0] o_result,
   output logic [3:0] o_dest_reg,
   output logic o_illegal_op
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic is_sat;
   logic is_pack;
   logic is_ext;
   logic sat_sub;
   logic sat_bytes;
   logic ext_signed;
   logic [1:0] ext_size;
   logic ext_add;
   logic [31:0] sat_res;
   logic [31:0] ext_res;
   logic [31:0] pack_res;
   logic [31:0] shl_b;
   logic [31:0] asr_b;
   logic [5:0] asr_amt;
   logic [31:0] next_result;
   logic next_result_valid;
   logic [3:0] next_dest_reg;
   logic next_illegal_op;
   logic [31:0] alu_out;
   logic known;

   // Map an extend opcode onto its width class
   function automatic logic [1:0] ext_size_of(input logic [4:0] op);
      logic [1:0] s;
      s = 2'd0;
      if (op == ssa_pkg::OP_SIGN_EXT_HALF || op == ssa_pkg::OP_ZERO_EXT_HALF ||
          op == ssa_pkg::OP_SIGN_EXT_HALF_ADD || op == ssa_pkg::OP_ZERO_EXT_HALF_ADD) begin
         s = 2'd1;
      end else if (op == ssa_pkg::OP_SIGN_EXT_DUAL_BYTE ||
                   op == ssa_pkg::OP_ZERO_EXT_DUAL_BYTE ||
                   op == ssa_pkg::OP_SIGN_EXT_DUAL_BYTE_ADD ||
                   op == ssa_pkg::OP_ZERO_EXT_DUAL_BYTE_ADD) begin
         s = 2'd2;
      end
      return s;
   endfunction

   // Operation class and sub-mode decode
   always_comb begin
      is_sat = (i_opcode <= ssa_pkg::OP_SAT_SUB_BYTES);
      is_pack = (i_opcode == ssa_pkg::OP_PACK_BOTTOM_TOP) ||
                (i_opcode == ssa_pkg::OP_PACK_TOP_BOTTOM);
      is_ext = (i_opcode >= ssa_pkg::OP_SIGN_EXT_BYTE) &&
               (i_opcode <= ssa_pkg::OP_ZERO_EXT_DUAL_BYTE_ADD);
      known = is_sat | is_pack | is_ext;
      sat_sub = (i_opcode == ssa_pkg::OP_SAT_SUB_HALVES) ||
                (i_opcode == ssa_pkg::OP_SAT_SUB_BYTES);
      sat_bytes = (i_opcode == ssa_pkg::OP_SAT_ADD_BYTES) ||
                  (i_opcode == ssa_pkg::OP_SAT_SUB_BYTES);
      ext_signed = (i_opcode == ssa_pkg::OP_SIGN_EXT_BYTE) ||
                   (i_opcode == ssa_pkg::OP_SIGN_EXT_HALF) ||
                   (i_opcode == ssa_pkg::OP_SIGN_EXT_DUAL_BYTE) ||
                   (i_opcode == ssa_pkg::OP_SIGN_EXT_BYTE_ADD) ||
                   (i_opcode == ssa_pkg::OP_SIGN_EXT_HALF_ADD) ||
                   (i_opcode == ssa_pkg::OP_SIGN_EXT_DUAL_BYTE_ADD);
      ext_add = (i_opcode >= ssa_pkg::OP_SIGN_EXT_BYTE_ADD) &&
                (i_opcode <= ssa_pkg::OP_ZERO_EXT_DUAL_BYTE_ADD);
      ext_size = ext_size_of(i_opcode);
   end

   // ------------------------------------------------------------
   // Lane saturating arithmetic
   // ------------------------------------------------------------
   ssa_sat_lanes u_sat (
      .i_a(i_op_a),
      .i_b(i_op_b),
      .i_sub(sat_sub),
      .i_bytes(sat_bytes),
      .o_res(sat_res)
   );

   // ------------------------------------------------------------
   // Extend and extend-add
   // ------------------------------------------------------------
   ssa_extend u_ext (
      .i_a(i_op_a),
      .i_src(i_op_b),
      .i_rot(i_rotate_right_amount),
      .i_signed(ext_signed),
      .i_size(ext_size),
      .i_add(ext_add),
      .o_res(ext_res)
   );

   // ------------------------------------------------------------
   // Halfword pack
   // ------------------------------------------------------------
   // Shift amount code zero selects a full 32-bit right shift
   assign asr_amt = (i_shift_amount == 5'h00) ? ssa_pkg::FULL_ASR :
                    {1'b0, i_shift_amount};
   assign shl_b = i_op_b << i_shift_amount;
   assign asr_b = 32'($signed(i_op_b) >>> asr_amt);

   // Halves assembled from first operand and shifted second
   always_comb begin
      if (i_opcode == ssa_pkg::OP_PACK_BOTTOM_TOP) begin
         pack_res = {shl_b[31:16], i_op_a[15:0]};
      end else begin
         pack_res = {i_op_a[31:16], asr_b[15:0]};
      end
   end

   // ------------------------------------------------------------
   // Result selection and write-back
   // ------------------------------------------------------------
   // Only the result word leaves; no flag path exists
   always_comb begin
      if (is_sat) begin
         alu_out = sat_res;
      end else if (is_pack) begin
         alu_out = pack_res;
      end else if (is_ext) begin
         alu_out = ext_res;
      end else begin
         alu_out = ssa_pkg::RESULT_RESET;
      end
   end

   // Failed condition holds result and destination and raises no write
   always_comb begin
      next_result = o_result;
      next_dest_reg = o_dest_reg;
      next_result_valid = 1'b0;
      next_illegal_op = 1'b0;
      if (i_valid && i_cond_pass) begin
         if (known) begin
            next_result = alu_out;
            next_dest_reg = i_dest_reg;
            next_result_valid = 1'b1;
         end else begin
            next_illegal_op = 1'b1;
         end
      end
   end

   // Output registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= ssa_pkg::RESULT_RESET;
         o_dest_reg <= 4'h0;
         o_result_valid <= 1'b0;
         o_illegal_op <= 1'b0;
      end else begin
         o_result <= next_result;
         o_dest_reg <= next_dest_reg;
         o_result_valid <= next_result_valid;
         o_illegal_op <= next_illegal_op;
      end
   end
endmodule

// >>> testbench/ssa_alu_props.sv
// Purpose: Port checker for the lane ALU
// Assumes: One clock, reset active low
// Notes: Results are tied to the issuing cycle
`timescale 1ns/1ps
module ssa_alu_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic i_cond_pass,
   input wire logic [4:0] i_opcode,
   input wire logic [31:0] i_op_a,
   input wire logic [31:0] i_op_b,
   input wire logic [4:0] i_shift_amount,
   input wire logic [1:0] i_rotate_right_amount,
   input wire logic [3:0] i_dest_reg,
   input wire logic o_result_valid,
   input wire logic [31:0] o_result,
   input wire logic [3:0] o_dest_reg,
   input wire logic o_illegal_op
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic tk;
   logic [4:0] op;
   logic [1:0] rt;
   // Taken request qualifiers
   assign tk = i_valid && i_cond_pass;
   assign op = i_opcode;
   assign rt = i_rotate_right_amount;
   a_refused_no_write: assert property (!tk |=> !o_result_valid && $stable(o_result))
      else $error("refused op changed result");
   a_add_not_below: assert property (tk && op == 5'h00 |=> o_result[15:0] >= $past(i_op_a[15:0]))
      else $error("halfword add below operand");
   a_sub_not_above: assert property (tk && op == 5'h03 |=> o_result[7:0] <= $past(i_op_a[7:0]))
      else $error("byte sub above operand");
   a_pack_bt_low: assert property (tk && op == 5'h04 |=> o_result[15:0] == $past(i_op_a[15:0]))
      else $error("pack low half wrong");
   a_pack_tb_high: assert property (tk && op == 5'h05 |=> o_result[31:16] == $past(i_op_a[31:16]))
      else $error("pack high half wrong");
   a_lsl_top_half: assert property (tk && op == 5'h04 |=>
      o_result[31:16] == 16'(($past(i_op_b) << $past(i_shift_amount)) >> 16))
      else $error("left shift wrong");
   a_asr_full_fill: assert property (tk && op == 5'h05 && i_shift_amount == 5'h00 |=>
      o_result[15:0] == {16{$past(i_op_b[31])}})
      else $error("full shift fill wrong");
   a_zext_byte: assert property (tk && op == 5'h07 && rt == 2'h0 |=>
      o_result == {24'h00_0000, $past(i_op_b[7:0])})
      else $error("byte zero extend wrong");
   a_zext_half_rot: assert property (tk && op == 5'h09 && rt == 2'h2 |=>
      o_result == {16'h0000, $past(i_op_b[31:16])})
      else $error("rotated half extend wrong");
   a_dual_zext: assert property (tk && op == 5'h0B && rt == 2'h0 |=>
      o_result == {8'h00, $past(i_op_b[23:16]), 8'h00, $past(i_op_b[7:0])})
      else $error("dual extend wrong");
endmodule
bind ssa_alu ssa_alu_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(i_valid),
   .i_cond_pass(i_cond_pass), .i_opcode(i_opcode), .i_op_a(i_op_a), .i_op_b(i_op_b),
   .i_shift_amount(i_shift_amount), .i_rotate_right_amount(i_rotate_right_amount),
   .i_dest_reg(i_dest_reg), .o_result_valid(o_result_valid), .o_result(o_result),
   .o_dest_reg(o_dest_reg), .o_illegal_op(o_illegal_op));

// >>> testbench/ssa_regfile.sv
// Purpose: Register file model on the issuing side
// Assumes: Writes land on result pulses
// Notes: Indices 13 to 15 are never written
`timescale 1ns/1ps
module ssa_regfile (
   input wire logic i_clk_sys,
   input wire logic i_wr,
   input wire logic [3:0] i_idx,
   input wire logic [31:0] i_data
);
   logic [31:0] regs [0:12];
   // Writeback of each accepted result
   always_ff @(posedge i_clk_sys) begin
      if (i_wr && i_idx < 4'hD) begin
         regs[i_idx] <= i_data;
      end
   end
endmodule

// >>> testbench/ssa_alu_tb.sv
// Purpose: Self-checking bench for the lane ALU
// Assumes: Result one cycle after a taken op
// Notes: Expected results come from a local model
`timescale 1ns/1ps
module ssa_alu_tb;
   logic clk, rst_n, vld, cnd, rv, ill;
   logic [4:0] opc, sh;
   logic [31:0] opa, opb, res, last;
   logic [1:0] rt;
   logic [3:0] dst, rd, last_d;
   logic [15:0] lf;
   logic [36:0] q[$];
   int bad_count, checks_done;
   // ----------------------------------------
   // Model and tasks
   // ----------------------------------------
   function automatic logic [31:0] ref_f(logic [4:0] op, logic [31:0] a, b, logic [4:0] s,
                                         logic [1:0] t);
      logic [63:0] w;
      logic [31:0] y, e;
      logic sg;
      int m, x, n;
      y = 32'({b, b} >> (8 * t));
      sg = op inside {5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0D, 5'h0E};
      if (op < 5'h04) begin
         n = op[0] ? 8 : 16;
         m = (1 << n) - 1;
         e = '0;
         for (int i = 0; i < 32; i += n) begin
            x = int'((a >> i) & m) + (op[1] ? -int'((b >> i) & m) : int'((b >> i) & m));
            x = x < 0 ? 0 : (x > m ? m : x);
            e = e | (32'(x) << i);
         end
         return e;
      end
      e = b << s;
      if (op == 5'h04) return {e[31:16], a[15:0]};
      w = {{32{b[31]}}, b};
      w = $signed(w) >>> (s == 5'h00 ? 32 : int'(s));
      if (op == 5'h05) return {a[31:16], w[15:0]};
      if (op inside {5'h06, 5'h07, 5'h0C, 5'h0F}) e = {{24{sg & y[7]}}, y[7:0]};
      else if (op inside {5'h08, 5'h09, 5'h0D, 5'h10}) e = {{16{sg & y[15]}}, y[15:0]};
      else e = {{8{sg & y[23]}}, y[23:16], {8{sg & y[7]}}, y[7:0]};
      if (op < 5'h0C) return e;
      if (op inside {5'h0E, 5'h11}) return {a[31:16] + e[31:16], a[15:0] + e[15:0]};
      return a + e;
   endfunction
   // Two LFSR steps give one random word
   function automatic logic [31:0] r();
      logic [31:0] v;
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v[15:0] = lf;
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v[31:16] = lf;
      return v;
   endfunction
   task automatic chk(logic [36:0] seen, logic [36:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic iss(logic v, c, logic [4:0] op, logic [31:0] a, b, logic [4:0] s,
                      logic [1:0] t, logic [3:0] d);
      @(posedge clk);
      #1;
      vld = v;
      cnd = c;
      opc = op;
      opa = a;
      opb = b;
      sh = s;
      rt = t;
      dst = d;
      if (v && c) begin
         if (op <= 5'h11) last = ref_f(op, a, b, s, t);
         if (op <= 5'h11) last_d = d;
         q.push_back({op > 5'h11, last_d, last}); // Unknown op keeps old dest and result
      end
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ssa_alu u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_valid(vld), .i_cond_pass(cnd),
      .i_opcode(opc), .i_op_a(opa), .i_op_b(opb), .i_shift_amount(sh),
      .i_rotate_right_amount(rt), .i_dest_reg(dst), .o_result_valid(rv), .o_result(res),
      .o_dest_reg(rd), .o_illegal_op(ill));
   ssa_regfile u_rf (.i_clk_sys(clk), .i_wr(rv), .i_idx(rd), .i_data(res));
   // Clock
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // Compare each result pulse with the oldest note
   always @(negedge clk) begin
      if (rst_n && (rv !== 1'b0 || ill !== 1'b0)) begin
         if (q.size() == 0) chk(37'h0, 37'h1);
         else chk({ill, rd, res}, q.pop_front());
      end
   end
   // Directed edges, then random back-to-back traffic
   initial begin
      logic [31:0] a, b, m;
      {rst_n, vld, cnd, opc, opa, opb, sh, rt, dst} = '0;
      {bad_count, checks_done, last, last_d, lf} = {64'h0, 36'h0, 16'hDE27};
      repeat (4) @(posedge clk);
      #1 rst_n = 1;
      iss(1, 1, 5'h00, 32'hFFFF_0001, 32'h0002_0001, 5'h00, 2'h0, 4'h1);
      for (int k = 0; k < 80; k++) begin
         m = k % 4 == 3 ? 32'h1F : 32'(k % 4);
         iss(1, 1, 5'(k / 4), 32'hFFFF_80F0, 32'h8001_7F90, m[4:0], 2'(k), 4'h2);
         iss(1, 1, 5'(k / 4), 32'h8001_7F90, 32'hFFFF_80F0, m[4:0], 2'(k), 4'h3);
      end
      // Mid-run reset once the pipeline has drained
      iss(0, 0, 5'h00, 32'h0, 32'h0, 5'h00, 2'h0, 4'h0);
      @(posedge clk);
      #1 rst_n = 0;
      #1 chk({ill | rv, rd, res}, 37'h0); // Reset clears all outputs
      {last, last_d} = 36'h0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      for (int k = 0; k < 800; k++) begin
         a = r();
         b = r();
         m = r();
         iss(|m[1:0], |m[4:2], 5'(m[24:20] % 20), a, b, m[12:8], m[14:13],
             4'(m[19:16] % 13));
      end
      iss(0, 0, 5'h00, 32'h0, 32'h0, 5'h00, 2'h0, 4'h0);
      for (int k = 0; k < 10 && q.size() > 0; k++) @(posedge clk);
      if (q.size() > 0) bad_count++;
      @(posedge clk);
      chk(37'(u_rf.regs[last_d]), 37'(last));
      close_out();
   end
endmodule
